// ### acs_mod_model.sv
// modulator/filter sample source standing in front of the sequencer
`timescale 1ns/1ps
module acs_mod_model (
    input wire logic clk,
    input wire logic [15:0] level,
    output logic [15:0] sample
);
    // =====================================================
    // sample path
    // a steady level makes the captured zero-scale point predictable
    always_ff @(posedge clk) begin
        sample <= level;
    end
endmodule // acs_mod_model

// ### acs_pipe_delay.sv
// pipeline delay timer run before the first result after calibration
`timescale 1ns/1ps
module acs_pipe_delay #(
    parameter int CYCLES = acs_pkg::TP_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    output logic done
);
    logic [acs_pkg::TP_W-1:0] cnt_reg;
    logic done_reg;
    logic [acs_pkg::TP_W-1:0] el_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= acs_pkg::TP_W'(CYCLES);
            done_reg <= 1'b0;
        end else begin
            done_reg <= (cnt_reg == acs_pkg::TP_W'(1));
            cnt_reg <= (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        end
    end

    assign done = done_reg;

    // helper: cycles since start, for the bound check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            el_reg <= '0;
        end else if (start) begin
            el_reg <= '0;
        end else if (cnt_reg != '0) begin
            el_reg <= el_reg + 1'b1;
        end
    end

    AST_PIPE_MAX: assert property (@(posedge clk) disable iff (!arst_n)
        done_reg |-> el_reg < acs_pkg::TP_W'(CYCLES + 1) && $past(cnt_reg) == acs_pkg::TP_W'(1))
        else $error("pipeline delay overran its limit");
endmodule // acs_pipe_delay

// ### acs_pkg.sv
// constants and types shared by the calibration sequencer files
package acs_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MCLK_REF_HZ = 2_457_600;
    localparam int NOTCH_HZ_0 = 50;
    localparam int NOTCH_HZ_1 = 60;
    localparam int NOTCH_HZ_2 = 250;
    localparam int NOTCH_HZ_3 = 500;
    localparam int OUT_PERIOD_0 = CLK_HZ / NOTCH_HZ_0;
    localparam int OUT_PERIOD_1 = CLK_HZ / NOTCH_HZ_1;
    localparam int OUT_PERIOD_2 = CLK_HZ / NOTCH_HZ_2;
    localparam int OUT_PERIOD_3 = CLK_HZ / NOTCH_HZ_3;
    // pipeline delay limit, in master clock periods
    localparam longint TP_MAX_MCLK = 2000;
    localparam int TP_CYCLES = int'(TP_MAX_MCLK * CLK_HZ / MCLK_REF_HZ);
    localparam int PER_W = 19;
    localparam int TP_W = 15;
    // ==========================================================
    // calibration lengths in output periods
    localparam logic [3:0] CAL_SELF_CLR = 4'h6;
    localparam logic [3:0] CAL_SELF_DATA_READY_N = 4'h9;
    localparam logic [3:0] CAL_SYS_CLR = 4'h3;
    localparam logic [3:0] CAL_SYS_DATA_READY_N = 4'h4;
    localparam logic [3:0] CAL_SELF_ZS_END = 4'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SELF = 2'h1;
    localparam logic [1:0] MODE_ZS = 2'h2;
    localparam logic [1:0] MODE_FS = 2'h3;
    // ==========================================================
    // register map
    localparam logic [7:0] OFS_SETUP = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_EN = 8'h0C;
    localparam logic [7:0] OFS_INT_CLR = 8'h10;
    localparam logic [7:0] OFS_ZERO = 8'h14;
    localparam logic [7:0] OFS_FULL = 8'h18;
    localparam int OP_MODE_LO = 0;
    localparam int OP_MODE_HI = 1;
    localparam int NOTCH_SELECT_LO = 2;
    localparam int NOTCH_SELECT_HI = 3;
    localparam int GAIN_LO = 4;
    localparam int GAIN_HI = 5;
    localparam int UNIPOLAR_BIT = 6;
    localparam int STS_CAL_DONE = 0;
    localparam int STS_DATA_NEW = 1;
    localparam int STS_BUSY = 8;
    localparam int STS_DATA_READY_N_N = 9;
    localparam logic [1:0] NOTCH_RST = 2'h0;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [1:0] EVT_RST = 2'h0;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] MIDSCALE = 16'h8000;
    localparam logic [7:0] GAIN_X0 = 8'h01;
    localparam logic [7:0] GAIN_X1 = 8'h02;
    localparam logic [7:0] GAIN_X2 = 8'h20;
    localparam logic [7:0] GAIN_X3 = 8'h80;

    typedef enum logic [1:0] {ST_NORMAL, ST_CAL, ST_SETTLE, ST_PIPE} acs_state_e;
endpackage

// ### acs_rate_gen.sv
// output data rate generator: one tick per first-notch period
`timescale 1ns/1ps
module acs_rate_gen #(
    parameter int PERIOD_0 = acs_pkg::OUT_PERIOD_0,
    parameter int PERIOD_1 = acs_pkg::OUT_PERIOD_1,
    parameter int PERIOD_2 = acs_pkg::OUT_PERIOD_2,
    parameter int PERIOD_3 = acs_pkg::OUT_PERIOD_3
) (
    input wire logic clk,
    input wire logic arst_n,
    acs_rate_if.gen rg
);
    logic [acs_pkg::PER_W-1:0] cnt_reg;
    logic [acs_pkg::PER_W-1:0] per_last;
    logic tick_reg;

    always_comb begin
        case (rg.notch_sel)
            2'h0: per_last = acs_pkg::PER_W'(PERIOD_0 - 1);
            2'h1: per_last = acs_pkg::PER_W'(PERIOD_1 - 1);
            2'h2: per_last = acs_pkg::PER_W'(PERIOD_2 - 1);
            default: per_last = acs_pkg::PER_W'(PERIOD_3 - 1);
        endcase
    end

    // a shorter notch picked mid-period wraps at once instead of overrunning
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (rg.restart) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (cnt_reg >= per_last) begin
            cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign rg.tick = tick_reg;

    AST_NOTCH_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
        tick_reg && !$past(rg.restart) |-> $past(cnt_reg) >= $past(per_last) && cnt_reg == '0)
        else $error("rate tick not at end of notch period");
endmodule // acs_rate_gen

// ### acs_rate_if.sv
// output-period tick link between the sequencer and its rate generator
`timescale 1ns/1ps
interface acs_rate_if;
    logic [1:0] notch_sel;
    logic restart;
    logic tick;
    modport gen (input notch_sel, input restart, output tick);
    modport user (output notch_sel, output restart, input tick);
endinterface : acs_rate_if

// ### acs_top.sv
// calibration and conversion sequencer with APB register access
`timescale 1ns/1ps
// Behaviour
// - when a calibration ends, both mode bits return to zero
// - after any calibration one normal conversion runs, then data ready goes low
// - mode bits clear before data ready; clearing alone means no new result
// - post-calibration pipeline delay never exceeds 2000 master clock periods
// - mode 0,1 self calibration: bits clear after 6 periods, ready after 9 plus delay
// - mode 1,0 zero-scale system calibration: clear after 3, ready after 4 plus delay
// - mode 1,1 full-scale system calibration: clear after 3, ready after 4 plus delay
// - output register updates at the first notch rate chosen by notch select bits
// - at 2.4576 MHz master clock the notch rates span 50 Hz to 500 Hz
// - at 1 MHz the notch rates span 20 Hz to 200 Hz, scaling with clock
// - polarity bit changes only output coding and calibration points
// - gain setting selects 1, 2, 32 or 128
module acs_top #(
    parameter int PERIOD_0 = acs_pkg::OUT_PERIOD_0,
    parameter int PERIOD_1 = acs_pkg::OUT_PERIOD_1,
    parameter int PERIOD_2 = acs_pkg::OUT_PERIOD_2,
    parameter int PERIOD_3 = acs_pkg::OUT_PERIOD_3,
    parameter int PIPE_CYCLES = acs_pkg::TP_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] sample,
    output logic data_ready_n,
    output logic [1:0] gain_sel,
    output logic [7:0] pga_gain,
    output logic irq
);
    // ==========================================================
    // declarations
    acs_rate_if rif ();
    acs_pkg::acs_state_e state_reg;
    logic [1:0] mode_reg;
    logic [1:0] kind_reg;
    logic [1:0] notch_reg;
    logic [1:0] gain_reg;
    logic uni_reg;
    logic [3:0] cnt_reg;
    logic restart_reg;
    logic [15:0] data_reg;
    logic [15:0] zero_reg;
    logic [15:0] full_reg;
    logic [15:0] hold_reg;
    logic data_ready_n_n_reg;
    logic [1:0] sts_reg;
    logic [1:0] sts_next;
    logic [1:0] en_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] pga_reg;
    logic [31:0] rd_mux;
    logic mapped;
    logic acc;
    logic wr_setup;
    logic rd_data;
    logic cal_start;
    logic rtick;
    logic [3:0] clr_len;
    logic [3:0] data_ready_n_len;
    logic last_clr;
    logic last_data_ready_n;
    logic mode_done;
    logic pipe_start;
    logic pipe_done;
    logic new_evt;
    logic [15:0] coded_now;
    logic [15:0] coded_hold;

    // offset-corrected, saturated and coded per polarity
    function automatic logic [15:0] acs_code(input logic [15:0] s, input logic [15:0] zs,
                                             input logic uni);
        logic signed [16:0] d;
        logic [15:0] sat;
        d = $signed({s[15], s}) - $signed({zs[15], zs});
        if (d > 17'sh07FFF) begin
            sat = 16'h7FFF;
        end else if (d < -17'sh08000) begin
            sat = 16'h8000;
        end else begin
            sat = d[15:0];
        end
        if (uni) begin
            acs_code = sat[15] ? 16'h0000 : {sat[14:0], 1'b0};
        end else begin
            acs_code = sat ^ acs_pkg::MIDSCALE;
        end
    endfunction

    // ==========================================================
    // APB decode
    assign acc = psel && penable && pready_reg;
    assign wr_setup = acc && pwrite && (paddr == acs_pkg::OFS_SETUP);
    assign rd_data = acc && !pwrite && (paddr == acs_pkg::OFS_DATA);

    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            acs_pkg::OFS_SETUP: begin
                rd_mux[acs_pkg::OP_MODE_HI:acs_pkg::OP_MODE_LO] = mode_reg;
                rd_mux[acs_pkg::NOTCH_SELECT_HI:acs_pkg::NOTCH_SELECT_LO] = notch_reg;
                rd_mux[acs_pkg::GAIN_HI:acs_pkg::GAIN_LO] = gain_reg;
                rd_mux[acs_pkg::UNIPOLAR_BIT] = uni_reg;
            end
            acs_pkg::OFS_DATA: rd_mux[15:0] = data_reg;
            acs_pkg::OFS_STATUS: begin
                rd_mux[1:0] = sts_reg;
                rd_mux[acs_pkg::STS_BUSY] = (state_reg != acs_pkg::ST_NORMAL);
                rd_mux[acs_pkg::STS_DATA_READY_N_N] = data_ready_n_n_reg;
            end
            acs_pkg::OFS_INT_EN: rd_mux[1:0] = en_reg;
            acs_pkg::OFS_INT_CLR: rd_mux = 32'h0000_0000;
            acs_pkg::OFS_ZERO: rd_mux[15:0] = zero_reg;
            acs_pkg::OFS_FULL: rd_mux[15:0] = full_reg;
            default: mapped = 1'b0;
        endcase
    end

    // read data is captured in the setup cycle so the access phase is one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !mapped;
        end
    end

    // ==========================================================
    // setup register
    // nonzero mode starts
    assign cal_start = wr_setup && (state_reg == acs_pkg::ST_NORMAL) &&
                       (pwdata[acs_pkg::OP_MODE_HI:acs_pkg::OP_MODE_LO] != acs_pkg::MODE_NORMAL);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            notch_reg <= acs_pkg::NOTCH_RST;
            gain_reg <= acs_pkg::GAIN_RST;
            uni_reg <= 1'b0;
        end else if (wr_setup) begin
            notch_reg <= pwdata[acs_pkg::NOTCH_SELECT_HI:acs_pkg::NOTCH_SELECT_LO];
            gain_reg <= pwdata[acs_pkg::GAIN_HI:acs_pkg::GAIN_LO];
            uni_reg <= pwdata[acs_pkg::UNIPOLAR_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pga_reg <= acs_pkg::GAIN_X0;
        end else begin
            case (gain_reg)
                2'h0: pga_reg <= acs_pkg::GAIN_X0;
                2'h1: pga_reg <= acs_pkg::GAIN_X1;
                2'h2: pga_reg <= acs_pkg::GAIN_X2;
                default: pga_reg <= acs_pkg::GAIN_X3;
            endcase
        end
    end

    // ==========================================================
    // calibration sequencer
    assign rif.notch_sel = notch_reg;
    assign rif.restart = restart_reg;
    // a tick left over from before the restart is not counted
    assign rtick = rif.tick && !restart_reg;
    assign clr_len = (kind_reg == acs_pkg::MODE_SELF) ? acs_pkg::CAL_SELF_CLR
                                                      : acs_pkg::CAL_SYS_CLR;
    assign data_ready_n_len = (kind_reg == acs_pkg::MODE_SELF) ? acs_pkg::CAL_SELF_DATA_READY_N
                                                       : acs_pkg::CAL_SYS_DATA_READY_N;
    assign last_clr = (cnt_reg == clr_len - 4'h1);
    assign last_data_ready_n = (cnt_reg == data_ready_n_len - 4'h1);
    assign mode_done = (state_reg == acs_pkg::ST_CAL) && rtick && last_clr;
    assign pipe_start = (state_reg == acs_pkg::ST_SETTLE) && rtick && last_data_ready_n;

    acs_rate_gen #(
        .PERIOD_0(PERIOD_0),
        .PERIOD_1(PERIOD_1),
        .PERIOD_2(PERIOD_2),
        .PERIOD_3(PERIOD_3)
    ) u_rate (
        .clk(clk),
        .arst_n(arst_n),
        .rg(rif.gen)
    );

    acs_pipe_delay #(
        .CYCLES(PIPE_CYCLES)
    ) u_pipe (
        .clk(clk),
        .arst_n(arst_n),
        .start(pipe_start),
        .done(pipe_done)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= acs_pkg::ST_NORMAL;
            cnt_reg <= 4'h0;
            kind_reg <= acs_pkg::MODE_NORMAL;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= cal_start;
            if (rtick && state_reg != acs_pkg::ST_NORMAL) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
            case (state_reg)
                acs_pkg::ST_NORMAL: if (cal_start) begin
                    state_reg <= acs_pkg::ST_CAL;
                    cnt_reg <= 4'h0;
                    kind_reg <= pwdata[acs_pkg::OP_MODE_HI:acs_pkg::OP_MODE_LO];
                end
                acs_pkg::ST_CAL: if (mode_done) begin
                    state_reg <= acs_pkg::ST_SETTLE;
                end
                acs_pkg::ST_SETTLE: if (pipe_start) begin
                    state_reg <= acs_pkg::ST_PIPE;
                end
                acs_pkg::ST_PIPE: if (pipe_done) begin
                    state_reg <= acs_pkg::ST_NORMAL;
                end
                default: state_reg <= acs_pkg::ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= acs_pkg::MODE_NORMAL;
        end else if (cal_start) begin
            mode_reg <= pwdata[acs_pkg::OP_MODE_HI:acs_pkg::OP_MODE_LO];
        end else if (mode_done) begin
            mode_reg <= acs_pkg::MODE_NORMAL;
        end
    end

    // calibration points: zero-scale then full-scale for self calibration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_reg <= acs_pkg::DATA_RST;
            full_reg <= acs_pkg::DATA_RST;
        end else if (state_reg == acs_pkg::ST_CAL && rtick) begin
            if ((kind_reg == acs_pkg::MODE_SELF && cnt_reg == acs_pkg::CAL_SELF_ZS_END) ||
                (kind_reg == acs_pkg::MODE_ZS && last_clr)) begin
                zero_reg <= sample;
            end
            if (last_clr && kind_reg != acs_pkg::MODE_ZS) begin
                full_reg <= sample;
            end
        end
    end

    // ==========================================================
    // results and data ready
    // polarity only codes data
    assign coded_now = acs_code(sample, zero_reg, uni_reg);
    assign coded_hold = acs_code(hold_reg, zero_reg, uni_reg);
    assign new_evt = (state_reg == acs_pkg::ST_NORMAL && rtick && !cal_start) ||
                     (state_reg == acs_pkg::ST_PIPE && pipe_done);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_reg <= acs_pkg::DATA_RST;
            hold_reg <= acs_pkg::DATA_RST;
        end else begin
            if (pipe_start) begin
                hold_reg <= sample;
            end
            if (state_reg == acs_pkg::ST_PIPE && pipe_done) begin
                data_reg <= coded_hold;
            end else if (new_evt) begin
                data_reg <= coded_now;
            end
        end
    end

    // ready only after result; a new result beats a data read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_ready_n_n_reg <= 1'b1;
        end else if (cal_start) begin
            data_ready_n_n_reg <= 1'b1;
        end else if (new_evt) begin
            data_ready_n_n_reg <= 1'b0;
        end else if (rd_data) begin
            data_ready_n_n_reg <= 1'b1;
        end
    end

    // ==========================================================
    // interrupt status, enable and clear
    always_comb begin
        sts_next = sts_reg;
        if (acc && pwrite && paddr == acs_pkg::OFS_INT_CLR) begin
            sts_next = sts_next & ~pwdata[1:0];
        end
        sts_next[acs_pkg::STS_CAL_DONE] = sts_next[acs_pkg::STS_CAL_DONE] | mode_done;
        sts_next[acs_pkg::STS_DATA_NEW] = sts_next[acs_pkg::STS_DATA_NEW] | new_evt;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sts_reg <= acs_pkg::EVT_RST;
            en_reg <= acs_pkg::EVT_RST;
            irq_reg <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            irq_reg <= |(sts_reg & en_reg);
            if (acc && pwrite && paddr == acs_pkg::OFS_INT_EN) begin
                en_reg <= pwdata[1:0];
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign data_ready_n = data_ready_n_n_reg;
    assign gain_sel = gain_reg;
    assign pga_gain = pga_reg;
    assign irq = irq_reg;

    // ==========================================================
    // checks
    AST_MODE_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        mode_done |=> mode_reg == acs_pkg::MODE_NORMAL && state_reg == acs_pkg::ST_SETTLE)
        else $error("mode bits not cleared at calibration end");
    AST_DATA_READY_N_AFTER: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == acs_pkg::ST_PIPE && pipe_done |=> !data_ready_n && sts_reg[1])
        else $error("data ready not asserted after calibration");
    AST_CLEAR_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == acs_pkg::ST_SETTLE |-> data_ready_n && mode_reg == acs_pkg::MODE_NORMAL)
        else $error("data ready before mode bits cleared");
    AST_SELF_LEN: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(|mode_reg) && kind_reg == acs_pkg::MODE_SELF |-> $past(cnt_reg) == 4'h5
        && cnt_reg == 4'h6 && state_reg == acs_pkg::ST_SETTLE)
        else $error("self calibration length wrong");
    AST_SYS_LEN: assert property (@(posedge clk) disable iff (!arst_n)
        pipe_start && kind_reg != acs_pkg::MODE_SELF |-> cnt_reg == 4'h3)
        else $error("system calibration length wrong");
    AST_POLARITY: assert property (@(posedge clk) disable iff (!arst_n)
        wr_setup && pwdata[acs_pkg::GAIN_HI:acs_pkg::GAIN_LO] == gain_reg
        |=> ##1 $stable(gain_sel) && $stable(pga_gain))
        else $error("polarity change touched the input channel");
    AST_GAIN_SET: assert property (@(posedge clk) disable iff (!arst_n)
        pga_gain == 8'h01 || pga_gain == 8'h02 || pga_gain == 8'h20 || pga_gain == 8'h80)
        else $error("gain outside the four settings");
    AST_CAL_START: assert property (@(posedge clk) disable iff (!arst_n)
        cal_start |=> state_reg == acs_pkg::ST_CAL && mode_reg != acs_pkg::MODE_NORMAL
        && data_ready_n)
        else $error("calibration did not start");
endmodule // acs_top

// ### tb.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module tb;
    // =====================================================
    // signals
    localparam int PIPE = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] level = 16'h0100;
    logic [15:0] sample;
    logic data_ready_n;
    logic [1:0] gain_sel;
    logic [7:0] pga_gain;
    logic irq;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0 = 0;
    acs_top #(.PERIOD_0(40), .PERIOD_1(30), .PERIOD_2(20), .PERIOD_3(10),
        .PIPE_CYCLES(PIPE)) acs_top_i (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
        .data_ready_n(data_ready_n), .gain_sel(gain_sel), .pga_gain(pga_gain), .irq(irq));
    acs_mod_model acs_mod_model_i (.clk(clk), .level(level), .sample(sample));
    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // =====================================================
    // tasks
    task automatic final_report();
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h", $time, msg, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready is sampled before this edge's updates land
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic waitto(input int t);
        while (cyc < t0 + t) @(posedge clk);
    endtask
    // run one calibration and judge both completion indications
    task automatic cal(input logic [1:0] m, input logic [1:0] n, input int p,
        input int nc, input int nd);
        apb(1'b1, acs_pkg::OFS_SETUP, {28'h0000000, n, m});
        t0 = cyc;
        waitto(nc * p - 5);
        apb(1'b0, acs_pkg::OFS_SETUP, 32'h00000000);
        chk(rd[1:0] != 2'h0, 1'b1, "mode cleared early"); // count
        waitto(nc * p + 4);
        apb(1'b0, acs_pkg::OFS_SETUP, 32'h00000000);
        chk(rd[1:0], 2'h0, "mode not cleared");
        chk(data_ready_n, 1'b1, "ready before mode clear");
        waitto(nd * p + PIPE - 2);
        chk(data_ready_n, 1'b1, "ready early");
        waitto(nd * p + PIPE + 5);
        chk(data_ready_n, 1'b0, "ready late");
    endtask
    // =====================================================
    // scenarios
    task automatic sc_reset();
        chk(data_ready_n, 1'b1, "ready reset");
        chk(pga_gain, 8'h01, "gain reset");
        apb(1'b1, 8'h20, 32'h00000001);
        chk({er, rd}, {1'b1, 32'h00000000}, "unmapped");
    endtask
    task automatic sc_gain();
        logic [7:0] tbl [4] = '{8'h01, 8'h02, 8'h20, 8'h80};
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, acs_pkg::OFS_SETUP, 32'h0000000C | (g << 4));
            // the gain value lags the gain code by one register stage
            @(posedge clk);
            chk({gain_sel, pga_gain}, {g[1:0], tbl[g]}, "gain");
        end
    endtask
    task automatic sc_cal();
        apb(1'b1, acs_pkg::OFS_INT_EN, 32'h00000001);
        cal(acs_pkg::MODE_SELF, 2'h3, 10, 6, 9);
        chk(irq, 1'b1, "irq raise");
        apb(1'b0, acs_pkg::OFS_STATUS, 32'h00000000);
        chk(rd, 32'h00000003, "status after cal");
        apb(1'b1, acs_pkg::OFS_INT_CLR, 32'h00000001);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "irq clear");
        apb(1'b1, acs_pkg::OFS_INT_EN, 32'h00000000);
        cal(acs_pkg::MODE_ZS, 2'h2, 20, 3, 4);
        chk(irq, 1'b0, "irq masked");
        // a new input level shows which calibration point the full-scale mode captures
        level <= 16'h0180;
        cal(acs_pkg::MODE_FS, 2'h3, 10, 3, 4);
        apb(1'b0, acs_pkg::OFS_ZERO, 32'h00000000);
        chk(rd, 32'h00000100, "zero point moved");
        apb(1'b0, acs_pkg::OFS_FULL, 32'h00000000);
        chk(rd, 32'h00000180, "full point not taken");
    endtask
    // coding relative to the captured zero point, read once per polarity setting after 30 cycles
    task automatic sc_coding();
        level <= 16'h0140;
        apb(1'b1, acs_pkg::OFS_SETUP, 32'h0000000C);
        repeat (30) @(posedge clk);
        apb(1'b0, acs_pkg::OFS_DATA, 32'h00000000);
        chk(rd, 32'h00008040, "bipolar");
        apb(1'b1, acs_pkg::OFS_SETUP, 32'h0000004C);
        repeat (30) @(posedge clk);
        apb(1'b0, acs_pkg::OFS_DATA, 32'h00000000);
        chk(rd, 32'h00000080, "unipolar");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        sc_reset();
        sc_gain();
        sc_cal();
        sc_coding();
        final_report();
    end
endmodule // tb
